// *** rtl/sioc_pkg.sv ***
// Shared constants for the configuration register slice 05h..09h
package sioc_pkg;
    // Configuration indices
    localparam logic [7:0] IDX_FLOPPY_SETUP = 8'h05;
    localparam logic [7:0] IDX_DRIVE_TYPE = 8'h06;
    localparam logic [7:0] IDX_PWR_BOOT = 8'h07;
    localparam logic [7:0] IDX_DEC_LOW = 8'h08;
    localparam logic [7:0] IDX_DEC_HIGH = 8'h09;
    // Reset values
    localparam logic [7:0] RST_FLOPPY_SETUP = 8'h00;
    localparam logic [7:0] RST_DRIVE_TYPE = 8'hff;
    localparam logic [7:0] RST_PWR_BOOT = 8'h00;
    localparam logic [7:0] RST_DEC_LOW = 8'h00;
    localparam logic [7:0] RST_DEC_HIGH = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    // Writable masks, reserved bits stay zero
    localparam logic [7:0] MSK_FLOPPY_SETUP = 8'h7f;
    localparam logic [7:0] MSK_DRIVE_TYPE = 8'hff;
    localparam logic [7:0] MSK_PWR_BOOT = 8'hf3;
    localparam logic [7:0] MSK_DEC_LOW = 8'hf0;
    localparam logic [7:0] MSK_DEC_HIGH = 8'hc7;
    // Floppy setup fields
    localparam int FS_PUSH_PULL = 0;
    localparam int FS_TRISTATE = 1;
    localparam int FS_NON_BURST = 2;
    localparam int FS_DENS_LO = 3;
    localparam int FS_DENS_HI = 4;
    localparam int FS_SWAP = 5;
    localparam int FS_EXT4 = 6;
    // Density override codes
    localparam logic [1:0] DENS_NORMAL = 2'h0;
    localparam logic [1:0] DENS_FORCE_HI = 2'h2;
    localparam logic [1:0] DENS_FORCE_LO = 2'h3;
    // Power and boot fields
    localparam int PB_BOOT_LO = 0;
    localparam int PB_BOOT_HI = 1;
    localparam int PB_PD_LO = 4;
    localparam int PB_PD_HI = 7;
    // Decoder fields
    localparam int DL_ADDR_LO = 4;
    localparam int DL_ADDR_HI = 7;
    localparam int DH_ADDR_LO = 0;
    localparam int DH_ADDR_HI = 2;
    localparam int DH_CFG_LO = 6;
    localparam int DH_CFG_HI = 7;
    typedef enum logic [1:0] {
        SIOC_DEC_OFF, SIOC_DEC_BYTE, SIOC_DEC_BLK8, SIOC_DEC_BLK16
    } sioc_dec_cfg_t;
    // Parallel port extended mode codes
    localparam logic [2:0] ECR_EPP = 3'h4;
    localparam logic [2:0] ECR_SPP = 3'h0;
    // Music-interface timing: 125 kHz reference, baud is a quarter of it
    localparam int CLK_HZ = 200000000;
    localparam int MIDI_REF_HZ = 125000;
    localparam int MIDI_BAUD_HZ = 31250;
    localparam int MIDI_REF_CYC = CLK_HZ / MIDI_REF_HZ;
    localparam int MIDI_BAUD_REFS = MIDI_REF_HZ / MIDI_BAUD_HZ;
endpackage

// *** rtl/sioc_addr_match.sv ***
// General-purpose address decoder compare
`timescale 1ns/1ps
module sioc_addr_match (
    input wire logic [10:0] addr,
    input wire logic [10:4] base,
    input wire sioc_pkg::sioc_dec_cfg_t cfg,
    output logic match
);
    // Upper bits compared in every enabled size, low nibble depends on block size
    always_comb begin
        match = 1'b0;
        case (cfg)
            sioc_pkg::SIOC_DEC_OFF: match = 1'b0;
            sioc_pkg::SIOC_DEC_BYTE: match = (addr[10:4] == base) && (addr[3:0] == 4'h0);
            sioc_pkg::SIOC_DEC_BLK8: match = (addr[10:4] == base) && !addr[3];
            sioc_pkg::SIOC_DEC_BLK16: match = (addr[10:4] == base);
            default: match = 1'b0;
        endcase
    end
endmodule // sioc_addr_match

// *** rtl/sioc_cfg_regs.sv ***
// Configuration registers 05h..09h with floppy pin control and address decode
`timescale 1ns/1ps
// Functional notes
// - Floppy setup at index 05h, reset 00h
// - Bit0 chooses open-drain or push-pull floppy outputs
// - Bit1 tri-states all floppy outputs
// - Bit2 non-burst strobes request, interrupt per byte while the FIFO is enabled
// - Bit5 swaps drive and motor 0,1
// - Bit6 presents encoded selects for external decoder
// - Bit7 reads zero
// - Output controls leave parallel-port floppy pins alone
// - Density one override reaches the floppy pin only while outputs active; the parallel-port copy shows it even when tri-stated
// - Drive type IDs at 06h, reset FFh
// - Power and boot at 07h, reset 00h
// - Bits1:0 choose boot drive A or B
// - Bits7:4 auto power-down enables, cleared at reset
// - Decoder low at 08h, bits3:0 read zero
// - Decoder high at 09h, address and config
// - Config code picks off, byte, 8, 16 block
// - Decode output needs upper select low
// - Music mode gives 125 kHz and 31.25 kbaud
// - Extended control selects EPP 100, SPP 000
module sioc_cfg_regs #(
    parameter int MIDI_REF_CYC = sioc_pkg::MIDI_REF_CYC,
    parameter int MIDI_BAUD_REFS = sioc_pkg::MIDI_BAUD_REFS
) (
    input wire logic mclk,
    input wire logic rstn,
    // Configuration port, from the config-state logic on mclk
    input wire logic cfg_active,
    input wire logic index_wr_en,
    input wire logic data_wr_en,
    input wire logic data_rd_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic rd_hit,
    output logic [7:0] config_index_register,
    // Floppy core side, on mclk
    input wire logic [1:0] fdc_drive_num,
    input wire logic fdc_drive_en,
    input wire logic [1:0] fdc_motor_on,
    input wire logic fdc_density_one,
    input wire logic density_one_override_bit,
    input wire logic fdc_dma_req,
    input wire logic fdc_irq,
    input wire logic fdc_byte_done,
    input wire logic fdc_fifo_en,
    // Floppy pins; select and motor values active low, request and interrupt active high
    output logic [1:0] fdd_sel_o,
    output logic [1:0] fdd_sel_oe_n,
    output logic [1:0] fdd_mot_o,
    output logic [1:0] fdd_mot_oe_n,
    output logic drive_density_one,
    output logic drive_density_one_oe_n,
    output logic floppy_dma_request,
    output logic floppy_interrupt_request,
    // Floppy signals routed onto the parallel port pins
    output logic [1:0] pp_sel_o,
    output logic [1:0] pp_mot_o,
    output logic pp_density_one,
    // Setup views for other blocks
    output logic [7:0] drive_type_ids,
    output logic [1:0] boot_drive,
    output logic [3:0] auto_power_down,
    // Address decode pins from the host bus
    input wire logic [10:0] isa_addr,
    input wire logic upper_address_select_n,
    output logic aux_address_decode,
    // Music-interface clocks
    input wire logic midi_en,
    output logic midi_ref_tick,
    output logic midi_baud_tick,
    // Parallel port extended mode
    input wire logic pp_combined_mode,
    input wire logic [2:0] ecr_mode,
    output logic pp_epp_sel,
    output logic pp_spp_sel
);
    logic [7:0] index_ff;
    logic [7:0] setup_ff;
    logic [7:0] dtype_ff;
    logic [7:0] pwr_ff;
    logic [7:0] dlow_ff;
    logic [7:0] dhigh_ff;
    logic [7:0] rd_data_ff;
    logic rd_valid_ff;
    logic rd_hit_ff;
    logic [7:0] nxt_rd_data;
    logic nxt_rd_hit;
    logic wr_ok;
    // Pin outputs
    logic [1:0] sel_o_ff, sel_oe_ff, mot_o_ff, mot_oe_ff;
    logic den_o_ff, den_oe_ff;
    logic [1:0] pp_sel_ff, pp_mot_ff;
    logic pp_den_ff;
    logic [1:0] nxt_sel_n, nxt_mot_n;
    logic nxt_den;
    // DMA strobing
    logic dreq_ff, irq_ff, dreq_hold_ff;
    // Decoder
    logic [10:0] addr_s1_ff, addr_s2_ff;
    logic ucs_s1_ff, ucs_s2_ff;
    logic dec_ff;
    logic dec_match;
    // Music timing
    logic [$clog2(MIDI_REF_CYC)-1:0] ref_cnt_ff;
    logic [$clog2(MIDI_BAUD_REFS+1)-1:0] baud_cnt_ff;
    logic ref_ff, baud_ff;
    logic epp_ff, spp_ff;

    // Pin driver: {value, enable_n}; open-drain only drives a low level
    function automatic logic [1:0] pin_drive(input logic val, input logic pp,
                                             input logic tri_en);
        if (tri_en) begin
            pin_drive = {1'b1, 1'b1};
        end else if (pp) begin
            pin_drive = {val, 1'b0};
        end else begin
            pin_drive = {1'b0, val};
        end
    endfunction

    // Index hit helper used by the register write paths
    function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
        idx_is = (idx == want);
    endfunction

    assign wr_ok = cfg_active && data_wr_en;

    // Configuration index, only while in configuration state
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            index_ff <= sioc_pkg::RST_INDEX;
        end else if (cfg_active && index_wr_en) begin
            index_ff <= wr_data;
        end
    end

    // Floppy setup register; bit 7 never stored
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            setup_ff <= sioc_pkg::RST_FLOPPY_SETUP;
        end else if (wr_ok && idx_is(index_ff, sioc_pkg::IDX_FLOPPY_SETUP)) begin
            setup_ff <= wr_data & sioc_pkg::MSK_FLOPPY_SETUP;
        end
    end

    // Drive type IDs, two bits per drive
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dtype_ff <= sioc_pkg::RST_DRIVE_TYPE;
        end else if (wr_ok && idx_is(index_ff, sioc_pkg::IDX_DRIVE_TYPE)) begin
            dtype_ff <= wr_data & sioc_pkg::MSK_DRIVE_TYPE;
        end
    end

    // Power-down enables and boot drive
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pwr_ff <= sioc_pkg::RST_PWR_BOOT;
        end else if (wr_ok && idx_is(index_ff, sioc_pkg::IDX_PWR_BOOT)) begin
            pwr_ff <= wr_data & sioc_pkg::MSK_PWR_BOOT;
        end
    end

    // Decoder address and configuration
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dlow_ff <= sioc_pkg::RST_DEC_LOW;
            dhigh_ff <= sioc_pkg::RST_DEC_HIGH;
        end else if (wr_ok && idx_is(index_ff, sioc_pkg::IDX_DEC_LOW)) begin
            dlow_ff <= wr_data & sioc_pkg::MSK_DEC_LOW;
        end else if (wr_ok && idx_is(index_ff, sioc_pkg::IDX_DEC_HIGH)) begin
            dhigh_ff <= wr_data & sioc_pkg::MSK_DEC_HIGH;
        end
    end

    // Read mux; other indices belong to neighbouring slices
    always_comb begin
        nxt_rd_data = 8'h00;
        nxt_rd_hit = 1'b1;
        case (index_ff)
            sioc_pkg::IDX_FLOPPY_SETUP: nxt_rd_data = setup_ff;
            sioc_pkg::IDX_DRIVE_TYPE: nxt_rd_data = dtype_ff;
            sioc_pkg::IDX_PWR_BOOT: nxt_rd_data = pwr_ff;
            sioc_pkg::IDX_DEC_LOW: nxt_rd_data = dlow_ff;
            sioc_pkg::IDX_DEC_HIGH: nxt_rd_data = dhigh_ff;
            default: nxt_rd_hit = 1'b0;
        endcase
    end

    // Read answer one cycle after the strobe, only in configuration state
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rd_data_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
            rd_hit_ff <= 1'b0;
        end else begin
            rd_valid_ff <= cfg_active && data_rd_en;
            if (cfg_active && data_rd_en) begin
                rd_data_ff <= nxt_rd_hit ? nxt_rd_data : 8'h00;
                rd_hit_ff <= nxt_rd_hit;
            end
        end
    end

    // Select and motor mapping: swap, then internal or encoded selects
    always_comb begin
        logic [1:0] num;
        logic [1:0] mot;
        num = fdc_drive_num;
        mot = fdc_motor_on;
        if (setup_ff[sioc_pkg::FS_SWAP] && !num[1]) begin
            num[0] = !num[0];
        end
        if (setup_ff[sioc_pkg::FS_SWAP]) begin
            mot = {mot[0], mot[1]};
        end
        if (setup_ff[sioc_pkg::FS_EXT4]) begin
            nxt_sel_n = fdc_drive_en ? ~num : 2'h3;
        end else begin
            nxt_sel_n[0] = !(fdc_drive_en && num == 2'h0);
            nxt_sel_n[1] = !(fdc_drive_en && num == 2'h1);
        end
        nxt_mot_n = ~mot;
    end

    // Density one: override codes, then the external force-high bit
    always_comb begin
        case (setup_ff[sioc_pkg::FS_DENS_HI:sioc_pkg::FS_DENS_LO])
            sioc_pkg::DENS_FORCE_HI: nxt_den = 1'b1;
            sioc_pkg::DENS_FORCE_LO: nxt_den = 1'b0;
            default: nxt_den = fdc_density_one;
        endcase
        if (density_one_override_bit) begin
            nxt_den = 1'b1;
        end
    end

    // Floppy pins; tri-state wins over every override
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sel_o_ff <= 2'h0;
            sel_oe_ff <= 2'h3;
            mot_o_ff <= 2'h0;
            mot_oe_ff <= 2'h3;
            den_o_ff <= 1'b0;
            den_oe_ff <= 1'b1;
        end else begin
            for (int i = 0; i < 2; i++) begin
                {sel_o_ff[i], sel_oe_ff[i]} <= pin_drive(nxt_sel_n[i],
                    setup_ff[sioc_pkg::FS_PUSH_PULL], setup_ff[sioc_pkg::FS_TRISTATE]);
                {mot_o_ff[i], mot_oe_ff[i]} <= pin_drive(nxt_mot_n[i],
                    setup_ff[sioc_pkg::FS_PUSH_PULL], setup_ff[sioc_pkg::FS_TRISTATE]);
            end
            {den_o_ff, den_oe_ff} <= pin_drive(nxt_den,
                setup_ff[sioc_pkg::FS_PUSH_PULL], setup_ff[sioc_pkg::FS_TRISTATE]);
        end
    end

    // Parallel-port copy ignores the output type and tri-state bits
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pp_sel_ff <= 2'h3;
            pp_mot_ff <= 2'h3;
            pp_den_ff <= 1'b1;
        end else begin
            pp_sel_ff <= nxt_sel_n;
            pp_mot_ff <= nxt_mot_n;
            pp_den_ff <= nxt_den;
        end
    end

    // Non-burst: request drops after each byte until the core re-raises it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dreq_hold_ff <= 1'b0;
            dreq_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            if (!fdc_dma_req) begin
                dreq_hold_ff <= 1'b0;
            end else if (fdc_byte_done) begin
                dreq_hold_ff <= 1'b1;
            end
            if (setup_ff[sioc_pkg::FS_NON_BURST] && fdc_fifo_en) begin
                dreq_ff <= fdc_dma_req && !dreq_hold_ff && !fdc_byte_done;
                irq_ff <= fdc_irq || fdc_byte_done;
            end else begin
                dreq_ff <= fdc_dma_req;
                irq_ff <= fdc_irq;
            end
        end
    end

    // Host address pins come from another domain: two stages first
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            addr_s1_ff <= 11'h000;
            addr_s2_ff <= 11'h000;
            ucs_s1_ff <= 1'b1;
            ucs_s2_ff <= 1'b1;
        end else begin
            addr_s1_ff <= isa_addr;
            addr_s2_ff <= addr_s1_ff;
            ucs_s1_ff <= upper_address_select_n;
            ucs_s2_ff <= ucs_s1_ff;
        end
    end

    sioc_addr_match u_match (
        .addr(addr_s2_ff),
        .base({dhigh_ff[sioc_pkg::DH_ADDR_HI:sioc_pkg::DH_ADDR_LO],
               dlow_ff[sioc_pkg::DL_ADDR_HI:sioc_pkg::DL_ADDR_LO]}),
        .cfg(sioc_pkg::sioc_dec_cfg_t'(dhigh_ff[sioc_pkg::DH_CFG_HI:sioc_pkg::DH_CFG_LO])),
        .match(dec_match)
    );

    // Decode output qualified by the upper select
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dec_ff <= 1'b0;
        end else begin
            dec_ff <= dec_match && !ucs_s2_ff;
        end
    end

    // Music reference divider; idle counters keep the ticks aligned to enable
    always_ff @(posedge mclk) begin
        if (!rstn || !midi_en) begin
            ref_cnt_ff <= '0;
            baud_cnt_ff <= '0;
            ref_ff <= 1'b0;
            baud_ff <= 1'b0;
        end else begin
            ref_ff <= 1'b0;
            baud_ff <= 1'b0;
            if (ref_cnt_ff == ($clog2(MIDI_REF_CYC))'(MIDI_REF_CYC - 1)) begin
                ref_cnt_ff <= '0;
                ref_ff <= 1'b1;
                if (baud_cnt_ff == ($clog2(MIDI_BAUD_REFS+1))'(MIDI_BAUD_REFS - 1)) begin
                    baud_cnt_ff <= '0;
                    baud_ff <= 1'b1;
                end else begin
                    baud_cnt_ff <= baud_cnt_ff + 1'b1;
                end
            end else begin
                ref_cnt_ff <= ref_cnt_ff + 1'b1;
            end
        end
    end

    // Extended parallel mode selection from the extended control code
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            epp_ff <= 1'b0;
            spp_ff <= 1'b0;
        end else begin
            epp_ff <= pp_combined_mode && (ecr_mode == sioc_pkg::ECR_EPP);
            spp_ff <= pp_combined_mode && (ecr_mode == sioc_pkg::ECR_SPP);
        end
    end

    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign rd_hit = rd_hit_ff;
    assign config_index_register = index_ff;
    assign fdd_sel_o = sel_o_ff;
    assign fdd_sel_oe_n = sel_oe_ff;
    assign fdd_mot_o = mot_o_ff;
    assign fdd_mot_oe_n = mot_oe_ff;
    assign drive_density_one = den_o_ff;
    assign drive_density_one_oe_n = den_oe_ff;
    assign floppy_dma_request = dreq_ff;
    assign floppy_interrupt_request = irq_ff;
    assign pp_sel_o = pp_sel_ff;
    assign pp_mot_o = pp_mot_ff;
    assign pp_density_one = pp_den_ff;
    assign drive_type_ids = dtype_ff;
    assign boot_drive = pwr_ff[sioc_pkg::PB_BOOT_HI:sioc_pkg::PB_BOOT_LO];
    assign auto_power_down = pwr_ff[sioc_pkg::PB_PD_HI:sioc_pkg::PB_PD_LO];
    assign aux_address_decode = dec_ff;
    assign midi_ref_tick = ref_ff;
    assign midi_baud_tick = baud_ff;
    assign pp_epp_sel = epp_ff;
    assign pp_spp_sel = spp_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_setup_wr;
        wr_ok && index_ff == sioc_pkg::IDX_FLOPPY_SETUP;
    endsequence

    a_setup_write: assert property (s_setup_wr |=> setup_ff == ($past(wr_data) & sioc_pkg::MSK_FLOPPY_SETUP))
        else $error("setup write not stored");
    a_bit7_zero: assert property (rd_valid_ff && $past(index_ff) == sioc_pkg::IDX_FLOPPY_SETUP
        |-> !rd_data_ff[7])
        else $error("setup bit 7 read nonzero");
    a_tristate_all: assert property (setup_ff[sioc_pkg::FS_TRISTATE] ##1
        setup_ff[sioc_pkg::FS_TRISTATE] |-> &{sel_oe_ff, mot_oe_ff, den_oe_ff})
        else $error("floppy output driven while tri-stated");
    a_push_pull: assert property ($past(setup_ff[1:0]) == 2'h1 |-> sel_oe_ff == 2'h0)
        else $error("push-pull select not driven");
    a_ignore_outside: assert property (data_wr_en && !cfg_active |=> $stable(setup_ff)
        && $stable(pwr_ff) && $stable(dlow_ff))
        else $error("write outside configuration took effect");
    a_low_reserved: assert property (dlow_ff[3:0] == 4'h0 && pwr_ff[3:2] == 2'h0)
        else $error("reserved bits set");
    a_decode_qual: assert property (ucs_s2_ff |=> !dec_ff)
        else $error("decode asserted without upper select");
    a_decode_off: assert property (dhigh_ff[7:6] == 2'h0 ##1 dhigh_ff[7:6] == 2'h0
        |-> !dec_ff)
        else $error("disabled decoder asserted");
    a_byte_strobe: assert property (setup_ff[2] && fdc_fifo_en && fdc_byte_done
        |=> !dreq_ff)
        else $error("request not dropped after byte");
    a_midi_baud: assert property (baud_ff |-> ref_ff)
        else $error("baud tick off reference");
    a_epp_code: assert property (pp_combined_mode && ecr_mode == 3'h4 |=> epp_ff && !spp_ff)
        else $error("EPP not selected");
endmodule // sioc_cfg_regs

// *** tb/sioc_host_model.sv ***
// Host model driving the configuration index and data ports
`timescale 1ns/1ps
module sioc_host_model (
    input wire logic mclk,
    output logic cfg_active,
    output logic index_wr_en,
    output logic data_wr_en,
    output logic data_rd_en,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        cfg_active = 1'b1;
        {index_wr_en, data_wr_en, data_rd_en} = 3'h0;
        wr_data = 8'h5a;
    end
    // Index first, then the data strobe; the bus shows a changing pattern when idle
    task automatic access(input logic [7:0] idx, input logic rd, input logic [7:0] val);
        @(negedge mclk);
        index_wr_en = 1'b1;
        wr_data = idx;
        @(negedge mclk);
        index_wr_en = 1'b0;
        data_wr_en = !rd;
        data_rd_en = rd;
        wr_data = rd ? ~idx : val;
        @(negedge mclk);
        {data_wr_en, data_rd_en} = 2'h0;
        wr_data = ~wr_data;
    endtask
    // Configuration state level; called just after a falling edge
    task automatic set_cfg(input logic on);
        cfg_active = on;
    endtask
    task automatic write_reg(input logic [7:0] idx, input logic [7:0] val);
        access(idx, 1'b0, val);
    endtask
    // Read data is taken in the cycle that rd_valid stands; a bounded wait covers refusal
    task automatic read_reg(input logic [7:0] idx, output logic [7:0] val, output logic ok);
        int n;
        n = 0;
        access(idx, 1'b1, 8'h00);
        while (rd_valid !== 1'b1 && n < 3) begin
            @(negedge mclk);
            n++;
        end
        ok = (rd_valid === 1'b1);
        val = rd_data;
    endtask
endmodule // sioc_host_model

// *** tb/superio_config_regs_05_09_tb_top.sv ***
// Self-checking bench for configuration registers 05h..09h
`timescale 1ns/1ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, e, a); end end
module superio_config_regs_05_09_tb_top;
    logic mclk, rstn, cfg_active, index_wr_en, data_wr_en, data_rd_en, rd_valid, rd_hit;
    logic [7:0] wr_data, rd_data, config_index_register, drive_type_ids;
    logic [1:0] fdc_drive_num, fdc_motor_on, fdd_sel_o, fdd_sel_oe_n, fdd_mot_o, fdd_mot_oe_n;
    logic fdc_drive_en, fdc_density_one, density_one_override_bit, fdc_dma_req, fdc_irq;
    logic fdc_byte_done, fdc_fifo_en, drive_density_one, drive_density_one_oe_n;
    logic floppy_dma_request, floppy_interrupt_request, pp_density_one, upper_address_select_n;
    logic [1:0] pp_sel_o, pp_mot_o, boot_drive;
    logic [3:0] auto_power_down;
    logic [10:0] isa_addr;
    logic aux_address_decode, midi_en, midi_ref_tick, midi_baud_tick, pp_combined_mode;
    logic [2:0] ecr_mode;
    logic pp_epp_sel, pp_spp_sel, ok;
    logic [7:0] v;
    int n_errors = 0;
    int total_checks = 0;
    int nr, nb;
    logic [7:0] idx [5] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
    logic [7:0] rst [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk [5] = '{8'h7f, 8'hff, 8'hf3, 8'hf0, 8'hc7};
    // Floppy pin table: setup value, motor pins, motor enables, density pin, density enable
    logic [7:0] fs [4] = '{8'h00, 8'h01, 8'h21, 8'h03};
    logic [5:0] fx [4] = '{6'b00_10_0_1, 6'b10_00_1_0, 6'b01_00_1_0, 6'b11_11_1_1};
    // Decoder table: high register, host address, expected decode
    logic [7:0] dh [7] = '{8'h42, 8'h42, 8'h82, 8'h82, 8'hc2, 8'hc2, 8'h02};
    logic [10:0] da [7] = '{11'h230, 11'h231, 11'h237, 11'h238, 11'h23f, 11'h240, 11'h230};
    logic de [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    sioc_host_model host (.mclk(mclk), .cfg_active(cfg_active), .index_wr_en(index_wr_en),
        .data_wr_en(data_wr_en), .data_rd_en(data_rd_en), .wr_data(wr_data),
        .rd_data(rd_data), .rd_valid(rd_valid));
    // Short tick parameters keep the music-clock test brief
    sioc_cfg_regs #(.MIDI_REF_CYC(4), .MIDI_BAUD_REFS(2)) DUT (.*);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    initial begin
        #20000;
        n_errors++;
        test_done();
    end

    initial begin
        rstn = 1'b0;
        {fdc_drive_num, fdc_drive_en, fdc_motor_on, fdc_density_one} = 6'b00_1_01_0;
        {density_one_override_bit, fdc_dma_req, fdc_irq, fdc_byte_done, fdc_fifo_en} = 5'h10;
        isa_addr = 11'h000;
        upper_address_select_n = 1'b1;
        {midi_en, pp_combined_mode, ecr_mode} = 5'h00;
        settle(3);
        rstn = 1'b1;
        // Reset values, then a write outside configuration state
        for (int i = 0; i < 5; i++) begin
            host.read_reg(idx[i], v, ok);
            `CHK("reset value", rst[i], v)
        end
        host.set_cfg(1'b0);
        host.write_reg(8'h06, 8'h00);
        host.read_reg(8'h06, v, ok);
        `CHK("read refused", 1'b0, ok)
        host.set_cfg(1'b1);
        host.read_reg(8'h06, v, ok);
        `CHK("write ignored", 8'hff, v)
        host.read_reg(8'h0a, v, ok);
        `CHK("unmapped hit", 1'b0, rd_hit)
        `CHK("unmapped data", 8'h00, v)
        `CHK("index register", 8'h0a, config_index_register)
        $display("test registers reset done");
        // All ones written; reserved and read-only bits come back zero
        for (int i = 0; i < 5; i++) begin
            host.write_reg(idx[i], 8'hff);
            host.read_reg(idx[i], v, ok);
            `CHK("masked value", msk[i], v)
            `CHK("read hit", 1'b1, rd_hit)
        end
        `CHK("type ids", 8'hff, drive_type_ids)
        `CHK("boot drive", 2'h3, boot_drive)
        `CHK("power down", 4'hf, auto_power_down)
        $display("test registers masks done");
        // Output type, tristate, swap and density override
        for (int i = 0; i < 4; i++) begin
            host.write_reg(8'h05, fs[i]);
            settle(3);
            `CHK("floppy pins", fx[i], {fdd_mot_o, fdd_mot_oe_n, drive_density_one, drive_density_one_oe_n})
        end
        `CHK("sel tristate", 4'hf, {fdd_sel_o, fdd_sel_oe_n})
        `CHK("pp pins", 5'b10_10_1, {pp_sel_o, pp_mot_o, pp_density_one})
        fdc_drive_num = 2'h2;
        density_one_override_bit = 1'b0;
        host.write_reg(8'h05, 8'h41);
        settle(3);
        `CHK("ext selects", 2'b01, fdd_sel_o)
        `CHK("density normal", 1'b0, drive_density_one)
        `CHK("ext select enables", 2'b00, fdd_sel_oe_n)
        // Density codes 10 and 11 force the pin against the core value
        host.write_reg(8'h05, 8'h51);
        settle(2);
        `CHK("density forced high", 1'b1, drive_density_one)
        fdc_density_one = 1'b1;
        host.write_reg(8'h05, 8'h59);
        settle(2);
        `CHK("density forced low", 1'b0, drive_density_one)
        fdc_dma_req = 1'b1;
        settle(2);
        `CHK("burst request", 1'b1, floppy_dma_request)
        // Non-burst: one byte drops the request and strobes the interrupt
        host.write_reg(8'h05, 8'h04);
        fdc_fifo_en = 1'b1;
        fdc_byte_done = 1'b1;
        settle(1);
        fdc_byte_done = 1'b0;
        `CHK("byte strobe", 2'b01, {floppy_dma_request, floppy_interrupt_request})
        settle(2);
        `CHK("request held low", 2'b00, {floppy_dma_request, floppy_interrupt_request})
        fdc_dma_req = 1'b0;
        settle(1);
        fdc_dma_req = 1'b1;
        settle(2);
        `CHK("request re-armed", 1'b1, floppy_dma_request)
        $display("test floppy pins done");
        // Decoder sizes and the upper select qualifier
        host.write_reg(8'h08, 8'h3f);
        upper_address_select_n = 1'b0;
        for (int i = 0; i < 7; i++) begin
            host.write_reg(8'h09, dh[i]);
            isa_addr = da[i];
            settle(5);
            `CHK("decode", de[i], aux_address_decode)
        end
        host.write_reg(8'h09, 8'h42);
        upper_address_select_n = 1'b1;
        settle(5);
        `CHK("decode deselected", 1'b0, aux_address_decode)
        $display("test decoder done");
        // Music clock ticks over an exact multiple of the baud period
        midi_en = 1'b1;
        settle(20);
        {nr, nb} = 0;
        repeat (32) begin
            @(negedge mclk);
            nr += midi_ref_tick;
            nb += midi_baud_tick;
        end
        `CHK("ref ticks", 8, nr)
        `CHK("baud ticks", 4, nb)
        {pp_combined_mode, ecr_mode} = 4'hc;
        settle(3);
        `CHK("epp select", 2'b10, {pp_epp_sel, pp_spp_sel})
        ecr_mode = 3'h0;
        settle(3);
        `CHK("spp select", 2'b01, {pp_epp_sel, pp_spp_sel})
        $display("test midi and parallel done");
        test_done();
    end
endmodule // superio_config_regs_05_09_tb_top
